// ### design/msp_spi_slave.sv
`timescale 1ns/1ps
`include "msp_defines.svh"
// Behaviour
// RQ1 - Select falling edge starts command wait
// RQ2 - Select rising edge forces idle state
// RQ3 - Output changes on rise, input sampled fall
// RQ4 - Host drives on rise, samples on fall
// RQ5 - Output high impedance while select high
// RQ6 - Frame opens with eight-bit command byte
// RQ7 - Bit 7 direction, bits 6-0 index
// RQ8 - Marker 0xea: e5 enables, dc protects
// RQ9 - Codes 5a, a5, fa: A, B, reset
// RQ10 - Unmapped index reads as zero
// RQ11 - After data, wait for new command
// RQ12 - Bits shift most significant first
// RQ13 - Bytes shift most significant first
// RQ14 - Host leaves half-period gap between bytes
// RQ15 - Host raises select half-period after fall
// RQ16 - Read frame shifts register out on rises
// RQ17 - Protected writes need write enable first
// RQ18 - All read-write registers are protected
// RQ19 - Read data copied to echo 0x44
// RQ20 - Written data copied to echo 0x45
// RQ21 - Calibration checksum readable at 0x2d
// RQ22 - Choice pin selects synchronous or asynchronous
// RQ23 - Protected writes silently discarded
// RQ24 - Write enable persists until protect/reset

module msp_spi_slave (
  input wire logic clock,                             // 40 MHz system clock
  input wire logic rst_n,                             // Async reset, active low
  input wire logic chipSelectLow,                     // Select pin, active low
  input wire logic serialClock,                       // Link clock pin
  input wire logic hostToDevLine,                     // Serial data from host
  output logic devToHostLine,                         // Serial data to host
  output logic devToHostLineOe,                       // Output enable of data line
  input wire logic interfaceChoicePin,                // High selects this port
  output msp_pkg::msp_reg_req_type regReq,            // Core register request
  input wire msp_pkg::msp_reg_rsp_type regRsp,        // Core register answer
  input wire logic [23:0] calibChecksumIn,            // Checksum from core
  output msp_pkg::msp_special_type special            // Special command effects
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic sclkS1_q, sclkS2_q, sclkS3_q;
  logic csS1_q, csS2_q, csS3_q;
  logic mosiS1_q, mosiS2_q;
  logic choiceS1_q, choiceS2_q;

  // Two stages per pin; third stage on select and clock only finds edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      csS1_q <= 1'b1;
      csS2_q <= 1'b1;
      csS3_q <= 1'b1;
      mosiS1_q <= 1'b0;
      mosiS2_q <= 1'b0;
      choiceS1_q <= 1'b0;
      choiceS2_q <= 1'b0;
    end else begin
      sclkS1_q <= serialClock;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      csS1_q <= chipSelectLow;
      csS2_q <= csS1_q;
      csS3_q <= csS2_q;
      mosiS1_q <= hostToDevLine;
      mosiS2_q <= mosiS1_q;
      choiceS1_q <= interfaceChoicePin;
      choiceS2_q <= choiceS1_q;
    end
  end

  logic sclkRise, sclkFall, csFall, csRise, isSpi, selected, byteDone;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxShift_q, rxShift_d, rxByte;

  assign sclkRise = sclkS2_q & ~sclkS3_q;
  assign sclkFall = ~sclkS2_q & sclkS3_q;
  assign csFall = ~csS2_q & csS3_q;
  assign csRise = csS2_q & ~csS3_q;
  assign isSpi = (choiceS2_q == `MSP_CHOICE_SPI); // RQ22
  assign selected = isSpi & ~csS2_q;
  assign rxByte = {rxShift_q[6:0], mosiS2_q}; // RQ12
  assign byteDone = selected & sclkFall & (bitCnt_q == 3'd7);

  // ----------------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------------
  msp_pkg::msp_state_type state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [2:0] byteCnt_q, byteCnt_d;
  logic [31:0] txShift_q, txShift_d;
  logic [31:0] wrAcc_q, wrAcc_d;
  logic [31:0] rdEcho_q, rdEcho_d;
  logic [15:0] wrEcho_q, wrEcho_d;
  logic [23:0] checksum_q;
  logic txBit_q, txBit_d;
  logic oe_q, oe_d;
  msp_pkg::msp_reg_req_type req_q, req_d;
  msp_pkg::msp_special_type spc_q, spc_d;
  logic [31:0] rdVal;
  logic [2:0] rdLen, xferLen;
  logic localIdx;

  // Local registers answer ahead of the core
  always_comb begin
    localIdx = 1'b1;
    unique case (cmd_q[6:0])
      `MSP_IDX_CALIB_CHECKSUM: begin
        rdVal = {8'h00, checksum_q}; // RQ21
        rdLen = `MSP_LEN_CALIB_CHECKSUM;
      end
      `MSP_IDX_LAST_READ_ECHO: begin
        rdVal = rdEcho_q;
        rdLen = `MSP_LEN_LAST_READ_ECHO;
      end
      `MSP_IDX_LAST_WRITE_ECHO: begin
        rdVal = {16'h0000, wrEcho_q};
        rdLen = `MSP_LEN_LAST_WRITE_ECHO;
      end
      default: begin
        localIdx = 1'b0;
        rdLen = (regRsp.len > `MSP_LEN_MAX) ? `MSP_LEN_MAX : regRsp.len;
        rdVal = (rdLen == 3'd0) ? 32'h0000_0000 : regRsp.rdData; // RQ10
      end
    endcase
    xferLen = (rdLen == 3'd0) ? `MSP_LEN_UNMAPPED : rdLen;
  end

  // Next-state logic for the whole frame engine
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    rxShift_d = rxShift_q;
    cmd_d = cmd_q;
    byteCnt_d = byteCnt_q;
    txShift_d = txShift_q;
    wrAcc_d = wrAcc_q;
    rdEcho_d = rdEcho_q;
    wrEcho_d = wrEcho_q;
    txBit_d = txBit_q;
    oe_d = selected; // RQ5
    req_d = req_q;
    req_d.wrStb = 1'b0;
    spc_d = spc_q;
    spc_d.chanASel = 1'b0;
    spc_d.chanBSel = 1'b0;
    spc_d.resetReq = 1'b0;
    if (csRise || !selected) begin
      // Deselect aborts wherever the frame stood
      state_d = msp_pkg::ST_IDLE; // RQ2
      bitCnt_d = 3'd0;
      txBit_d = 1'b0;
    end else if (csFall || state_q == msp_pkg::ST_IDLE) begin
      state_d = msp_pkg::ST_CMD; // RQ1
      bitCnt_d = 3'd0;
      txBit_d = 1'b0;
    end else begin
      if (sclkRise && state_q == msp_pkg::ST_RDATA) begin
        txBit_d = txShift_q[31]; // RQ3 RQ16
        txShift_d = {txShift_q[30:0], 1'b0};
      end
      if (sclkFall) begin
        rxShift_d = rxByte; // RQ3
        bitCnt_d = bitCnt_q + 3'd1;
      end
      if (state_q == msp_pkg::ST_LOAD) begin
        // Core answer is taken in the same cycle the index is presented on regReq
        byteCnt_d = xferLen;
        if (!cmd_q[`MSP_CMD_DIR_BIT]) begin
          txShift_d = rdVal << (6'd8 * (6'(`MSP_LEN_MAX) - 6'(xferLen))); // RQ13
          rdEcho_d = rdVal; // RQ19
          state_d = msp_pkg::ST_RDATA;
        end else begin
          wrAcc_d = 32'h0000_0000;
          state_d = msp_pkg::ST_WDATA;
        end
      end
      if (byteDone) begin
        unique case (state_q)
          msp_pkg::ST_CMD: begin
            cmd_d = rxByte; // RQ6
            if (rxByte == `MSP_CMD_SPECIAL) begin
              state_d = msp_pkg::ST_SPECIAL; // RQ8
            end else begin
              req_d.idx = rxByte[6:0]; // RQ7
              state_d = msp_pkg::ST_LOAD;
            end
          end
          msp_pkg::ST_SPECIAL: begin
            unique case (rxByte)
              `MSP_SP_WRITE_EN: spc_d.writeEnabled = 1'b1; // RQ8 RQ17
              `MSP_SP_WRITE_PROT: spc_d.writeEnabled = 1'b0; // RQ8 RQ24
              `MSP_SP_CHAN_A: spc_d.chanASel = 1'b1; // RQ9
              `MSP_SP_CHAN_B: spc_d.chanBSel = 1'b1; // RQ9
              `MSP_SP_RESET: begin
                spc_d.resetReq = 1'b1; // RQ9
                spc_d.writeEnabled = 1'b0; // RQ24
              end
              default: ;
            endcase
            state_d = msp_pkg::ST_CMD; // RQ11
          end
          msp_pkg::ST_RDATA: begin
            byteCnt_d = byteCnt_q - 3'd1;
            if (byteCnt_q == 3'd1) begin
              state_d = msp_pkg::ST_CMD; // RQ11
            end
          end
          msp_pkg::ST_WDATA: begin
            wrAcc_d = {wrAcc_q[23:0], rxByte}; // RQ13
            byteCnt_d = byteCnt_q - 3'd1;
            if (byteCnt_q == 3'd1) begin
              wrEcho_d = wrAcc_d[15:0]; // RQ20
              // Every writable register is protected; local ones are read-only
              if (spc_q.writeEnabled && !localIdx && rdLen != 3'd0) begin // RQ18 RQ23
                req_d.wrStb = 1'b1; // RQ17
                req_d.wrData = wrAcc_d;
              end
              state_d = msp_pkg::ST_CMD; // RQ11
            end
          end
          default: state_d = msp_pkg::ST_CMD;
        endcase
      end
    end
  end

  // Frame engine registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= msp_pkg::ST_IDLE;
      bitCnt_q <= 3'd0;
      rxShift_q <= 8'h00;
      cmd_q <= 8'h00;
      byteCnt_q <= 3'd0;
      txShift_q <= 32'h0000_0000;
      wrAcc_q <= 32'h0000_0000;
      rdEcho_q <= 32'h0000_0000;
      wrEcho_q <= 16'h0000;
      checksum_q <= 24'h00_0000;
      txBit_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
      spc_q <= '0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      rxShift_q <= rxShift_d;
      cmd_q <= cmd_d;
      byteCnt_q <= byteCnt_d;
      txShift_q <= txShift_d;
      wrAcc_q <= wrAcc_d;
      rdEcho_q <= rdEcho_d;
      wrEcho_q <= wrEcho_d;
      checksum_q <= calibChecksumIn; // RQ21
      txBit_q <= txBit_d;
      oe_q <= oe_d;
      req_q <= req_d;
      spc_q <= spc_d;
    end
  end

  assign devToHostLine = txBit_q;
  assign devToHostLineOe = oe_q;
  assign regReq = req_q;
  assign special = spc_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence specialCode(logic [7:0] code);
    state_q == msp_pkg::ST_SPECIAL && byteDone && rxByte == code;
  endsequence

  sequence readLoad;
    state_q == msp_pkg::ST_LOAD && !cmd_q[`MSP_CMD_DIR_BIT] && selected && !csFall;
  endsequence

  AST_DESELECT_IDLE: assert property (csRise |=> state_q == msp_pkg::ST_IDLE) // RQ2
    else $error("Select release did not force idle");
  AST_SELECT_CMD: assert property (csFall && isSpi |=> state_q == msp_pkg::ST_CMD) // RQ1
    else $error("Select fall did not start command wait");
  AST_HIGH_Z: assert property (csS2_q |=> !devToHostLineOe) // RQ5
    else $error("Output driven while select high");
  AST_OUT_ON_RISE: assert property ($changed(txBit_q) && $past(state_q) == msp_pkg::ST_RDATA
                                    && $past(selected) |-> $past(sclkRise)) // RQ3
    else $error("Output changed away from a rising edge");
  AST_UNMAPPED_ZERO: assert property (readLoad and (rdLen == 3'd0) |=> txShift_q == 32'h0000_0000
                                      ##1 1'b1) // RQ10
    else $error("Unmapped read did not return zero");
  AST_READ_ECHO: assert property (readLoad |=> rdEcho_q == $past(rdVal)) // RQ19
    else $error("Read echo not updated");
  AST_WRITE_GATED: assert property (regReq.wrStb |-> $past(spc_q.writeEnabled)) // RQ23
    else $error("Write issued while protected");
  AST_WREN: assert property (specialCode(`MSP_SP_WRITE_EN) |=> special.writeEnabled [*2]) // RQ8
    else $error("Write enable not applied");
  AST_WRPROT: assert property (specialCode(`MSP_SP_WRITE_PROT) |=> !special.writeEnabled) // RQ24
    else $error("Write protect not applied");
  AST_CHAN_A: assert property (specialCode(`MSP_SP_CHAN_A) |=> special.chanASel ##1 !special.chanASel) // RQ9
    else $error("Channel A select not one pulse");
  AST_RETURN_CMD: assert property (state_q == msp_pkg::ST_RDATA && byteDone && byteCnt_q == 3'd1
                                   && !csRise |=> state_q == msp_pkg::ST_CMD) // RQ11
    else $error("Port did not return to command wait");

endmodule

// ### include/msp_defines.svh
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define MSP_CMD_DIR_BIT 7
`define MSP_CMD_SPECIAL 8'hea
`define MSP_SP_WRITE_EN 8'he5
`define MSP_SP_WRITE_PROT 8'hdc
`define MSP_SP_CHAN_A 8'h5a
`define MSP_SP_CHAN_B 8'ha5
`define MSP_SP_RESET 8'hfa

// ----------------------------------------------------------------------
// Local register indices and their byte lengths
// ----------------------------------------------------------------------
`define MSP_IDX_CALIB_CHECKSUM 7'h2d
`define MSP_IDX_LAST_READ_ECHO 7'h44
`define MSP_IDX_LAST_WRITE_ECHO 7'h45
`define MSP_LEN_CALIB_CHECKSUM 3'd3
`define MSP_LEN_LAST_READ_ECHO 3'd4
`define MSP_LEN_LAST_WRITE_ECHO 3'd2
`define MSP_LEN_UNMAPPED 3'd1
`define MSP_LEN_MAX 3'd4

// ----------------------------------------------------------------------
// Interface choice pin level that selects the synchronous serial port
// ----------------------------------------------------------------------
`define MSP_CHOICE_SPI 1'b1

`endif

// ### include/msp_pkg.sv
package msp_pkg;

  // Port state machine
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CMD     = 3'b001,
    ST_LOAD    = 3'b010,
    ST_RDATA   = 3'b011,
    ST_WDATA   = 3'b100,
    ST_SPECIAL = 3'b101
  } msp_state_type;

  // Request toward the metering core register file
  typedef struct packed {
    logic [6:0] idx;
    logic wrStb;
    logic [31:0] wrData;
  } msp_reg_req_type;

  // Answer from the core: len 0 means the index does not exist
  typedef struct packed {
    logic [31:0] rdData;
    logic [2:0] len;
  } msp_reg_rsp_type;

  // Special command effects
  typedef struct packed {
    logic writeEnabled;
    logic chanASel;
    logic chanBSel;
    logic resetReq;
  } msp_special_type;

endpackage

// ### verif/msp_host_model.sv
`timescale 1ns/1ps
module msp_host_model (
  input wire logic clock,           // System clock that paces the link
  output logic chipSelectLow,       // Select toward the device
  output logic serialClock,         // Link clock, still between frames
  output logic hostToDevLine,       // Serial data toward the device
  input wire logic devToHostLine,   // Device data output
  input wire logic devToHostLineOe  // Device output enable
);
  // ----------------------------------------
  // Link pacing
  // ----------------------------------------
  localparam int HALF = 4; // 100 ns half period, the fastest the port accepts
  logic lineSeen;

  // Released line floats up through the board pull-up
  assign lineSeen = devToHostLineOe ? devToHostLine : 1'b1;

  initial begin
    chipSelectLow = 1'b1;
    serialClock = 1'b0;
    hostToDevLine = 1'b0;
  end

  // Data line wanders while deselected so stale bits never look valid
  always @(posedge clock) begin
    if (chipSelectLow) begin
      hostToDevLine <= ~hostToDevLine;
    end
  end

  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  task automatic select_on();
    @(posedge clock);
    chipSelectLow <= 1'b0;
    repeat (HALF) @(posedge clock);
  endtask

  task automatic select_off();
    repeat (HALF) @(posedge clock);
    chipSelectLow <= 1'b1;
    repeat (2 * HALF) @(posedge clock);
  endtask

  // One byte, driven on rises and sampled in the low half
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      serialClock <= 1'b1;
      hostToDevLine <= tx[i];
      repeat (HALF) @(posedge clock);
      serialClock <= 1'b0;
      repeat (2) @(posedge clock);
      rx[i] = lineSeen;
      repeat (HALF - 3) @(posedge clock);
    end
    repeat (HALF) @(posedge clock);
  endtask

  // Cuts a frame short after a few bits
  task automatic abort_after(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      serialClock <= 1'b1;
      repeat (HALF) @(posedge clock);
      serialClock <= 1'b0;
      repeat (HALF - 1) @(posedge clock);
    end
    select_off();
  endtask
endmodule

// ### verif/tb_metering_spi_slave_port.sv
`timescale 1ns/1ps
module tb_metering_spi_slave_port;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic chipSelectLow, serialClock, hostToDevLine, devToHostLine, devToHostLineOe;
  logic interfaceChoicePin = 1'b1;
  logic [23:0] calibChecksumIn = 24'h000000;
  msp_pkg::msp_reg_req_type regReq;
  msp_pkg::msp_reg_rsp_type regRsp;
  msp_pkg::msp_special_type special;
  logic [31:0] coreMem [128];
  int unsigned refMem [128];
  int unsigned lastRead = 0;
  int unsigned lastWrite = 0;
  int weRef = 0;
  int expWr = 0;
  int miscompares = 0;
  int num_checks = 0;
  int wrCount = 0, chanACount = 0, chanBCount = 0, resetCount = 0;

  always #12.5 clock = ~clock;

  msp_spi_slave dut_u (.clock(clock), .rst_n(rst_n), .chipSelectLow(chipSelectLow), .serialClock(serialClock),
    .hostToDevLine(hostToDevLine), .devToHostLine(devToHostLine), .devToHostLineOe(devToHostLineOe),
    .interfaceChoicePin(interfaceChoicePin), .regReq(regReq), .regRsp(regRsp),
    .calibChecksumIn(calibChecksumIn), .special(special));
  msp_host_model host_u (.clock(clock), .chipSelectLow(chipSelectLow), .serialClock(serialClock),
    .hostToDevLine(hostToDevLine), .devToHostLine(devToHostLine), .devToHostLineOe(devToHostLineOe));

  // ----------------------------------------
  // Core register file and pulse counters
  // ----------------------------------------
  // Lengths cycle 1..4 below 0x40 so every byte count is exercised
  // Missing indices answer junk, so a zero read proves the port masks it
  always_comb begin
    regRsp.len = (regReq.idx < 7'h40) ? {1'b0, regReq.idx[1:0]} + 3'h1 : 3'h0;
    regRsp.rdData = (regReq.idx < 7'h40) ? coreMem[regReq.idx] : 32'hc3c3_3c3c;
  end

  // Pulses are counted, so a stuck strobe shows up as an extra count
  always @(posedge clock) begin
    if (regReq.wrStb === 1'b1) begin
      coreMem[regReq.idx] <= regReq.wrData;
      wrCount++;
    end
    if (special.chanASel === 1'b1) chanACount++;
    if (special.chanBSel === 1'b1) chanBCount++;
    if (special.resetReq === 1'b1) resetCount++;
  end

  // ----------------------------------------
  // Reference model and tasks
  // ----------------------------------------
  function automatic int len_of(input int idx);
    if (idx == 'h2d) return 3;
    if (idx == 'h44) return 4;
    if (idx == 'h45) return 2;
    if (idx < 'h40) return (idx % 4) + 1;
    return 1;
  endfunction

  function automatic logic [31:0] mask_of(input int n, input logic [31:0] v);
    return v & 32'((64'h1 << (8 * n)) - 64'h1);
  endfunction

  function automatic logic [31:0] exp_read(input int idx);
    if (idx == 'h2d) return {8'h00, calibChecksumIn};
    if (idx == 'h44) return lastRead;
    if (idx == 'h45) return lastWrite;
    if (idx >= 'h40) return 32'h00000000;
    return mask_of(len_of(idx), refMem[idx]);
  endfunction

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    num_checks++;
    if (got !== expv) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic rd_chk(input int idx);
    logic [7:0] b;
    logic [31:0] got;
    logic [31:0] e;
    e = exp_read(idx);
    got = 32'h00000000;
    host_u.xfer({1'b0, 7'(idx)}, b);
    for (int k = 0; k < len_of(idx); k++) begin
      host_u.xfer(8'h00, b);
      got = {got[23:0], b};
    end
    chk("read data", e, got);
    lastRead = e;
  endtask

  task automatic wr_reg(input int idx, input logic [31:0] v);
    logic [7:0] b;
    int n;
    n = len_of(idx);
    host_u.xfer({1'b1, 7'(idx)}, b);
    for (int k = n - 1; k >= 0; k--) host_u.xfer(v[8*k +: 8], b);
    lastWrite = mask_of(n, v) & 32'h0000ffff;
    if (weRef != 0 && idx < 'h40 && idx != 'h2d) begin
      refMem[idx] = mask_of(n, v);
      expWr++;
    end
  endtask

  task automatic sp(input logic [7:0] code);
    logic [7:0] b;
    host_u.xfer(8'hea, b);
    host_u.xfer(code, b);
    weRef = (code == 8'he5) ? 1 : (code == 8'hdc || code == 8'hfa) ? 0 : weRef;
    chk("write enable", weRef, {31'h0, special.writeEnabled});
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  // Whole run needs about 16000 cycles, so this only trips on a hang
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    int idx;
    logic [7:0] b;
    for (int i = 0; i < 128; i++) begin
      coreMem[i] = 32'h00000000;
      refMem[i] = 0;
    end
    void'($urandom(35));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("idle enable", 0, {31'h0, devToHostLineOe});
    host_u.select_on();
    wr_reg(5, 32'h00001234);
    rd_chk(5);
    rd_chk('h45);
    chk("write strobes", expWr, wrCount);
    sp(8'he5);
    host_u.select_off();
    chk("deselected enable", 0, {31'h0, devToHostLineOe});
    host_u.select_on();
    for (int t = 0; t < 12; t++) begin
      idx = $urandom_range(0, 63);
      if (idx == 'h2d) idx = 'h2e;
      wr_reg(idx, $urandom);
      rd_chk(idx);
      rd_chk('h44);
      rd_chk('h45);
    end
    chk("write strobes", expWr, wrCount);
    calibChecksumIn <= 24'($urandom);
    @(posedge clock);
    rd_chk('h2d);
    rd_chk('h50);
    wr_reg('h50, 32'h000000a7);
    wr_reg('h2d, 32'h00abcdef);
    rd_chk('h45);
    sp(8'h5a);
    sp(8'ha5);
    sp(8'hdc);
    sp(8'he5);
    sp(8'h3c);
    sp(8'hfa);
    chk("channel a pulses", 1, chanACount);
    chk("channel b pulses", 1, chanBCount);
    chk("reset pulses", 1, resetCount);
    sp(8'he5);
    host_u.xfer(8'h83, b);
    host_u.xfer(8'h5c, b);
    host_u.abort_after(3);
    chk("write strobes", expWr, wrCount);
    host_u.select_on();
    rd_chk(3);
    host_u.select_off();
    interfaceChoicePin <= 1'b0;
    host_u.select_on();
    host_u.xfer(8'h44, b);
    chk("other port enable", 0, {31'h0, devToHostLineOe});
    host_u.select_off();
    interfaceChoicePin <= 1'b1;
    end_sim();
  end
endmodule
